// ---- src/apmoc_fifo.sv ----
// Result word FIFO, flip-flop storage addressed by index.
// Assumes both sides run on clk; the drain side may stall.
`timescale 1ns/1ps
module apmoc_fifo #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0] count, next_count;
   logic push, pop;

   // Pointer and occupancy next values
   always_comb begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);
   end

   assign in_ready = (count != (AW + 1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else if (ce) begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   // Storage entries, one flop group per entry
   for (genvar i = 0; i < DEPTH; i++) begin : g_ent
      always_ff @(posedge clk) begin
         if (ce && push && wr_ptr == AW'(i)) begin
            mem[i] <= in_data;
         end
      end
   end
endmodule

// ---- src/apmoc_pkg.sv ----
// Constants shared by the converter power-mode and output-code logic.
// Assumes a 100 MHz system clock; all timing counts derive from it.
package apmoc_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int RES_BITS = 12;
   localparam int NAP_WAKE_NS = 350;
   // Least time, rounded up to whole cycles
   localparam int NAP_WAKE_CYC = (NAP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REF_SETTLE_US = 4000;
   localparam int REF_SETTLE_CYC_DEF = REF_SETTLE_US * 1000 / CLK_PERIOD_NS;
   localparam logic [2:0] NAP_PULSES = 3'h2;
   localparam logic [2:0] SLEEP_PULSES = 3'h4;
   localparam int FIFO_DEPTH = 16;
   localparam int WORD_BITS = RES_BITS + 1;
   localparam logic [11:0] BIPOLAR_MAX = 12'h7FF;
   localparam logic [11:0] UNIPOLAR_MAX = 12'hFFF;
   localparam logic [11:0] CODE_ZERO = 12'h000;
   typedef enum logic [1:0] {
      APMOC_ACTIVE,
      APMOC_NAP,
      APMOC_SLEEP,
      APMOC_WAKE
   } apmoc_pwr_e;
endpackage

// ---- src/apmoc_top.sv ----
// Power-state control and output-code formatting for a 12-bit serial converter.
// Assumes link_clk and conversion_start_in come from the host, asynchronous to clk.
// Notes on behaviour
// - Powers up active, ready to convert.
// - Power-down only via clock/start pulse combination.
// - Nap keeps reference alive, rest off.
// - Nap wake-up takes 350ns before conversion.
// - Low reference forces ready flag low.
// - Unipolar result is straight binary.
// - Bipolar result is two's complement.
// - Bipolar codes: -1 all ones, max 7FF.
// - Unipolar codes span 000 to FFF.
// - Clock low: two pulses nap, four sleep.
// - Clock rising edge wakes from power-down.
// - Ready flag leads result, set when settled.
// - Sleep cuts everything including reference.
`timescale 1ns/1ps
module apmoc_top
   import apmoc_pkg::*;
#(
   parameter int REF_SETTLE_CYC = REF_SETTLE_CYC_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic link_clk,
   input wire logic conversion_start_in,
   input wire logic bipolar_mode,
   input wire logic ref_pin_low,
   input wire logic result_valid,
   input wire logic [RES_BITS-1:0] result_raw,
   output logic word_valid,
   input wire logic word_ready,
   output logic [WORD_BITS-1:0] word_data,
   output logic power_active,
   output logic reference_on,
   output logic convert_allowed,
   output logic reference_ready_flag
);
   ////////////////////////////////////////////////////////////////////
   // Input synchronisers: two flops each before any logic looks
   logic [1:0] clk_sync, conversion_start_in_sync, bip_sync, ref_sync;
   logic clk_prev, conversion_start_in_prev;
   logic clk_s, conversion_start_in_s, clk_rise, conversion_start_in_rise, bip_s, ref_low_s;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_sync <= 2'h0;
         conversion_start_in_sync <= 2'h0;
         bip_sync <= 2'h0;
         ref_sync <= 2'h0;
         clk_prev <= 1'b0;
         conversion_start_in_prev <= 1'b0;
      end else if (ce) begin
         clk_sync <= {clk_sync[0], link_clk};
         conversion_start_in_sync <= {conversion_start_in_sync[0], conversion_start_in};
         bip_sync <= {bip_sync[0], bipolar_mode};
         ref_sync <= {ref_sync[0], ref_pin_low};
         clk_prev <= clk_sync[1];
         conversion_start_in_prev <= conversion_start_in_sync[1];
      end
   end

   // Edge detection reads second-stage flops and their one-cycle-delayed copies
   always_comb begin
      clk_s = clk_sync[1];
      conversion_start_in_s = conversion_start_in_sync[1];
      bip_s = bip_sync[1];
      ref_low_s = ref_sync[1];
      clk_rise = clk_s && !clk_prev;
      conversion_start_in_rise = conversion_start_in_s && !conversion_start_in_prev;
   end

   ////////////////////////////////////////////////////////////////////
   // Power state machine
   apmoc_pwr_e state, next_state;
   logic [2:0] pulse_cnt, next_pulse_cnt;
   logic [5:0] wake_cnt, next_wake_cnt;
   logic [31:0] settle_cnt, next_settle_cnt;
   logic ref_settled, next_ref_settled;

   // Pulse counting only runs while the link clock stays low, so a normal
   // conversion (clock toggling) can never be mistaken for a power-down request
   always_comb begin
      next_state = state;
      next_pulse_cnt = pulse_cnt;
      next_wake_cnt = wake_cnt;
      next_settle_cnt = settle_cnt;
      next_ref_settled = ref_settled;
      if (clk_s) begin
         next_pulse_cnt = 3'h0;
      end else if (conversion_start_in_rise && pulse_cnt != SLEEP_PULSES) begin
         next_pulse_cnt = pulse_cnt + 3'h1;
      end
      case (state)
         APMOC_ACTIVE: begin
            if (!clk_s && conversion_start_in_rise && pulse_cnt == NAP_PULSES - 3'h1) begin
               next_state = APMOC_NAP;
            end
         end
         APMOC_NAP: begin
            if (clk_rise) begin
               next_state = APMOC_WAKE;
               next_wake_cnt = 6'(NAP_WAKE_CYC - 1);
            end else if (!clk_s && conversion_start_in_rise && pulse_cnt == SLEEP_PULSES - 3'h1) begin
               next_state = APMOC_SLEEP;
               next_ref_settled = 1'b0;
            end
         end
         APMOC_SLEEP: begin
            if (clk_rise) begin
               next_state = APMOC_ACTIVE;
               next_settle_cnt = 32'(REF_SETTLE_CYC);
            end
         end
         APMOC_WAKE: begin
            // Conversions held off until the nap recovery time has passed
            if (wake_cnt == 6'h0) begin
               next_state = APMOC_ACTIVE;
            end else begin
               next_wake_cnt = wake_cnt - 6'h1;
            end
         end
         default: next_state = APMOC_ACTIVE;
      endcase
      // Reference ramps only while powered; sleep restarts the ramp
      if (state != APMOC_SLEEP && !ref_settled) begin
         if (settle_cnt == 32'h0) begin
            next_ref_settled = 1'b1;
         end else begin
            next_settle_cnt = settle_cnt - 32'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= APMOC_ACTIVE;
         pulse_cnt <= 3'h0;
         wake_cnt <= 6'h0;
         settle_cnt <= 32'h0;
         ref_settled <= 1'b1;
      end else if (ce) begin
         state <= next_state;
         pulse_cnt <= next_pulse_cnt;
         wake_cnt <= next_wake_cnt;
         settle_cnt <= next_settle_cnt;
         ref_settled <= next_ref_settled;
      end
   end

   assign power_active = (state == APMOC_ACTIVE);
   assign reference_on = (state != APMOC_SLEEP);
   assign convert_allowed = (state == APMOC_ACTIVE);

   ////////////////////////////////////////////////////////////////////
   // Output code formatting and flag
   logic [RES_BITS-1:0] code, next_code;
   logic flag, next_flag, fmt_valid, next_fmt_valid, fifo_ready;

   // Raw result is offset binary from the converter core; bipolar inverts
   // the top bit, giving two's complement with 000 at zero input
   always_comb begin
      next_flag = ref_settled && !ref_low_s && reference_on;
      next_code = code;
      next_fmt_valid = fmt_valid && !fifo_ready;
      if (result_valid && (!fmt_valid || fifo_ready)) begin
         next_fmt_valid = 1'b1;
         if (bip_s) begin
            next_code = {~result_raw[RES_BITS-1], result_raw[RES_BITS-2:0]};
         end else begin
            next_code = result_raw;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         code <= CODE_ZERO;
         flag <= 1'b0;
         fmt_valid <= 1'b0;
      end else if (ce) begin
         code <= next_code;
         flag <= next_flag;
         fmt_valid <= next_fmt_valid;
      end
   end

   assign reference_ready_flag = flag;

   // Flag sits above the code so it leaves first when shifted MSB-first
   apmoc_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .in_valid(fmt_valid),
      .in_ready(fifo_ready),
      .in_data({flag, code}),
      .out_valid(word_valid),
      .out_ready(word_ready),
      .out_data(word_data)
   );

   ////////////////////////////////////////////////////////////////////
   // Checks
   // Clock enable belongs inside the sequence, which cannot be an operand of &&
   sequence s_two_pulses_low;
      ce && !clk_s && conversion_start_in_rise && pulse_cnt == 3'h1 && state == APMOC_ACTIVE;
   endsequence

   a_nap_entry: assert property (@(posedge clk) disable iff (!rst_n)
      s_two_pulses_low |=> state == APMOC_NAP)
      else $error("nap not entered after two pulses");
   a_wake_edge: assert property (@(posedge clk) disable iff (!rst_n)
      ce && state == APMOC_SLEEP && clk_rise |=> state == APMOC_ACTIVE)
      else $error("sleep not left on clock edge");
   a_wake_time: assert property (@(posedge clk) disable iff (!rst_n)
      ce && state == APMOC_NAP && clk_rise |=> !convert_allowed [*8])
      else $error("conversion allowed too soon after nap");
   a_ref_sleep: assert property (@(posedge clk) disable iff (!rst_n)
      state == APMOC_SLEEP |-> !reference_on)
      else $error("reference alive in sleep");
   a_ref_nap: assert property (@(posedge clk) disable iff (!rst_n)
      state == APMOC_NAP |-> reference_on)
      else $error("reference off in nap");
   a_flag_low: assert property (@(posedge clk) disable iff (!rst_n)
      ce && ref_low_s |=> !reference_ready_flag)
      else $error("flag high with low reference");
   a_pulse_clear: assert property (@(posedge clk) disable iff (!rst_n)
      ce && clk_s |=> pulse_cnt == 3'h0)
      else $error("pulse count kept with clock high");
   a_bip_code: assert property (@(posedge clk) disable iff (!rst_n)
      ce && result_valid && !fmt_valid && bip_s
      |=> code[RES_BITS-1] == !$past(result_raw[RES_BITS-1]))
      else $error("bipolar sign wrong");
   a_uni_code: assert property (@(posedge clk) disable iff (!rst_n)
      ce && result_valid && !fmt_valid && !bip_s |=> code == $past(result_raw))
      else $error("unipolar code altered");
endmodule

// ---- testbench/apmoc_host_model.sv ----
// Host serial-port model: link clock in frames, start pulses, word drain.
// Assumes the block's clk; the link clock rests low between frames.
`timescale 1ns/1ps
module apmoc_host_model
   import apmoc_pkg::*;
(
   input wire logic clk,
   output logic link_clk,
   output logic conversion_start_in,
   output logic word_ready,
   input wire logic word_valid,
   input wire logic [WORD_BITS-1:0] word_data
);
   logic accept;
   logic toggle;
   logic [WORD_BITS-1:0] got[$];
   ////////////////////////////////////////////////////////////////////////////////
   // Link clock stands still outside frames, keeping the lines quiet
   initial begin
      link_clk = 1'h0;
      conversion_start_in = 1'h0;
      word_ready = 1'h0;
      accept = 1'h0;
      toggle = 1'h0;
   end
   // Drain stalls every other cycle so words must hold
   always @(posedge clk) begin
      toggle <= ~toggle;
      word_ready <= accept & toggle;
      if (word_valid && word_ready) begin
         got.push_back(word_data);
      end
   end
   // Start pulse; wide spacing because the pins pass a synchroniser
   task automatic pulse_conversion_start_in();
      @(posedge clk) conversion_start_in <= 1'h1;
      repeat (4) @(posedge clk);
      conversion_start_in <= 1'h0;
      repeat (4) @(posedge clk);
   endtask
   // One 80 ns link clock period; its rising edge wakes the device
   task automatic frame();
      @(posedge clk) link_clk <= 1'h1;
      repeat (4) @(posedge clk);
      link_clk <= 1'h0;
      repeat (3) @(posedge clk);
   endtask
endmodule

// ---- testbench/apmoc_top_tb.sv ----
// Self-checking bench for the power-mode and output-code block.
// Assumes the host model in its own file and a shortened settle count.
`timescale 1ns/1ps
module apmoc_top_tb
   import apmoc_pkg::*;
;
   localparam int SETTLE = 20;
   logic clk, rst_n, ce, bipolar_mode, ref_pin_low, result_valid;
   logic [RES_BITS-1:0] result_raw;
   logic link_clk, conversion_start_in, word_ready, word_valid;
   logic [WORD_BITS-1:0] word_data;
   logic power_active, reference_on, convert_allowed, reference_ready_flag;
   logic [WORD_BITS-1:0] exp[$];
   int mismatches = 0;
   int compares = 0;
   ////////////////////////////////////////////////////////////////////////////////
   apmoc_top #(.REF_SETTLE_CYC(SETTLE)) apmoc_top_i (.clk(clk), .rst_n(rst_n), .ce(ce),
      .link_clk(link_clk), .conversion_start_in(conversion_start_in),
      .bipolar_mode(bipolar_mode), .ref_pin_low(ref_pin_low), .result_valid(result_valid),
      .result_raw(result_raw), .word_valid(word_valid), .word_ready(word_ready),
      .word_data(word_data), .power_active(power_active), .reference_on(reference_on),
      .convert_allowed(convert_allowed), .reference_ready_flag(reference_ready_flag));
   apmoc_host_model apmoc_host_model_i (.clk(clk), .link_clk(link_clk),
      .conversion_start_in(conversion_start_in), .word_ready(word_ready),
      .word_valid(word_valid), .word_data(word_data));
   // 100 MHz clock
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [WORD_BITS-1:0] e,
         input logic [WORD_BITS-1:0] s);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, e, s);
      end
   endtask
   // Back-to-back results, valid held high across the burst
   task automatic push_all(input logic [RES_BITS-1:0] q[$]);
      foreach (q[i]) begin
         @(posedge clk) result_valid <= 1'h1;
         result_raw <= q[i];
      end
      @(posedge clk) result_valid <= 1'h0;
   endtask
   // Bounded wait for the host to collect every expected word
   task automatic drain();
      int k;
      k = 0;
      repeat (5) @(posedge clk);
      chk("word_valid", WORD_BITS'(1), WORD_BITS'(word_valid));
      apmoc_host_model_i.accept <= 1'h1;
      while (apmoc_host_model_i.got.size() < exp.size() && k < 500) begin
         @(posedge clk);
         k++;
      end
      // The last pop lands at the edge that ends the wait; let the count settle
      @(posedge clk);
      foreach (exp[i]) chk("word_data", exp[i], apmoc_host_model_i.got[i]);
      chk("word_valid", WORD_BITS'(0), WORD_BITS'(word_valid));
      apmoc_host_model_i.accept <= 1'h0;
      apmoc_host_model_i.got.delete();
      exp.delete();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_codes();
      logic [RES_BITS-1:0] q[$] = '{12'h000, 12'h7FF, 12'h800, 12'hFFF};
      for (int m = 0; m < 2; m++) begin
         bipolar_mode <= m[0];
         repeat (6) @(posedge clk);
         foreach (q[i]) exp.push_back({1'h1, q[i] ^ (m[0] ? 12'h800 : 12'h000)});
         push_all(q);
         drain();
      end
      bipolar_mode <= 1'h0;
      ref_pin_low <= 1'h1;
      repeat (6) @(posedge clk);
      exp.push_back(13'h0123);
      push_all('{12'h123});
      drain();
      chk("flag", WORD_BITS'(0), WORD_BITS'(reference_ready_flag));
      ref_pin_low <= 1'h0;
      repeat (6) @(posedge clk);
      $display("test codes done");
   endtask
   // Sixteen words into a stalled drain, then out in order
   task automatic t_fill();
      logic [RES_BITS-1:0] q[$];
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         q.push_back(12'(i * 257));
         exp.push_back({1'h1, 12'(i * 257)});
      end
      push_all(q);
      drain();
      $display("test fill done");
   endtask
   task automatic t_nap();
      apmoc_host_model_i.pulse_conversion_start_in();
      apmoc_host_model_i.pulse_conversion_start_in();
      repeat (8) @(posedge clk);
      chk("power_active", WORD_BITS'(0), WORD_BITS'(power_active));
      chk("reference_on", WORD_BITS'(1), WORD_BITS'(reference_on));
      apmoc_host_model_i.frame();
      repeat (15) @(posedge clk);
      chk("convert_allowed", WORD_BITS'(0), WORD_BITS'(convert_allowed));
      repeat (30) @(posedge clk);
      chk("convert_allowed", WORD_BITS'(1), WORD_BITS'(convert_allowed));
      $display("test nap done");
   endtask
   task automatic t_sleep();
      repeat (4) apmoc_host_model_i.pulse_conversion_start_in();
      repeat (8) @(posedge clk);
      chk("reference_on", WORD_BITS'(0), WORD_BITS'(reference_on));
      apmoc_host_model_i.frame();
      repeat (2) @(posedge clk);
      chk("power_active", WORD_BITS'(1), WORD_BITS'(power_active));
      chk("flag", WORD_BITS'(0), WORD_BITS'(reference_ready_flag));
      repeat (40) @(posedge clk);
      chk("flag", WORD_BITS'(1), WORD_BITS'(reference_ready_flag));
      $display("test sleep done");
   endtask
   // A link clock edge between pulses must restart the count
   task automatic t_clear();
      apmoc_host_model_i.pulse_conversion_start_in();
      apmoc_host_model_i.frame();
      apmoc_host_model_i.pulse_conversion_start_in();
      repeat (8) @(posedge clk);
      chk("power_active", WORD_BITS'(1), WORD_BITS'(power_active));
      apmoc_host_model_i.pulse_conversion_start_in();
      repeat (8) @(posedge clk);
      chk("power_active", WORD_BITS'(0), WORD_BITS'(power_active));
      apmoc_host_model_i.frame();
      repeat (50) @(posedge clk);
      $display("test clear done");
   endtask
   // Clock enable low freezes everything, so start pulses must go unseen
   task automatic t_freeze();
      @(posedge clk) ce <= 1'h0;
      repeat (2) apmoc_host_model_i.pulse_conversion_start_in();
      @(posedge clk) ce <= 1'h1;
      repeat (8) @(posedge clk);
      chk("power_active", WORD_BITS'(1), WORD_BITS'(power_active));
      $display("test freeze done");
   endtask
   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog: the whole run needs well under 10 us
   initial begin
      #200us;
      mismatches++;
      summarize();
   end
   initial begin
      rst_n = 1'h0;
      ce = 1'h1;
      bipolar_mode = 1'h0;
      ref_pin_low = 1'h0;
      result_valid = 1'h0;
      result_raw = 12'h000;
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      repeat (10) @(posedge clk);
      chk("power_active", WORD_BITS'(1), WORD_BITS'(power_active));
      chk("convert_allowed", WORD_BITS'(1), WORD_BITS'(convert_allowed));
      chk("flag", WORD_BITS'(1), WORD_BITS'(reference_ready_flag));
      t_codes();
      t_fill();
      t_nap();
      t_sleep();
      t_clear();
      t_freeze();
      summarize();
   end
endmodule
